// >>> abx_exec.sv
// What this block does
// - Register sum, optional carry, five flags, one clock
// - Word immediate sum/difference on pair, two clocks
// - Register or constant difference, five flags, one clock
// - Borrow difference subtracts operand and carry
// - AND, OR, XOR store result, Z N V
// - Bit inversion gives ones minus value
// - Arithmetic inverse gives zero minus value
// - Mask set ORs, mask clear ANDs inverse
// - Zero/sign test ANDs register with itself
// - Register zeroing XORs register with itself
// - Products into R1:R0, Z and C, two clocks
// - Fractional products shift left one bit
// - Relative jump/call: pc plus offset plus one
// - Indirect jump/call load pc from Z
// - Extended indirect jump uses high byte, two clocks
// - Extended indirect call uses high byte, four clocks
// - Direct jump three clocks, direct call five
// - Compare-skip advances pc two or three
// - Register compare sets flags, writes nothing
`timescale 1ns/1ps
`include "abx_defs.svh"

module abx_exec
    import abx_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    input  wire logic     start_i,
    input  wire abx_req_t req_i,
    output logic          ready_o,
    output logic          done_o,
    output abx_res_t      res_o
);

    // ======================================================================
    // Arithmetic helpers.

    // Returns {H, V, C, result} of a + b + cin.
    function automatic logic [10:0] f_add(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin);
        logic [8:0] s;
        logic       h;
        logic       v;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        h = (a[3] & b[3]) | (b[3] & ~s[3]) | (~s[3] & a[3]);
        v = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
        return {h, v, s[8], s[7:0]};
    endfunction

    // Returns {H, V, C, result} of a - b - cin; C is the borrow.
    function automatic logic [10:0] f_sub(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin);
        logic [8:0] s;
        logic       h;
        logic       v;
        s = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        h = (~a[3] & b[3]) | (b[3] & s[3]) | (s[3] & ~a[3]);
        v = (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]);
        return {h, v, s[8], s[7:0]};
    endfunction

    // ======================================================================
    // Declarations.

    abx_state_t          state_q;
    logic [2:0]          cnt_q;
    logic                done_q;
    abx_res_t            res_q;
    abx_res_t            res_d;
    logic [2:0]          cyc_d;
    logic [10:0]         ar;
    logic [15:0]         wv;
    logic [15:0]         wr;
    logic [8:0]          ma;
    logic [8:0]          mb;
    logic [17:0]         mp;
    logic [15:0]         prod;
    logic [7:0]          lv;
    logic                cin;
    logic                fetch;
    logic [23:0]         ext_addr;
    logic [`ABX_PC_W-1:0] rel_addr;

    // Fetch hands over a new instruction only while the unit is idle.
    assign ready_o  = (state_q == ST_IDLE);
    assign fetch    = start_i & ready_o;
    assign ext_addr = {req_i.ext_high, req_i.zptr};
    assign rel_addr = req_i.pc + {{(`ABX_PC_W-12){req_i.offset[11]}}, req_i.offset}
                      + `ABX_PC_W'(1);

    // ======================================================================
    // Operation datapath.

    // Everything is worked out in the accept cycle and then held, so the
    // write-back stays stable however many clocks the instruction takes.
    always_comb begin
        res_d         = '0;
        res_d.wr_idx  = req_i.rd_idx;
        res_d.flags   = req_i.sreg;
        res_d.flag_we = `ABX_MSK_NONE;
        cyc_d         = `ABX_CYC_ALU;
        ar            = '0;
        lv            = `ABX_BYTE_ZERO;
        cin           = 1'b0;
        wv            = {req_i.rd_hi_val, req_i.rd_val};
        wr            = '0;
        ma            = '0;
        mb            = '0;
        mp            = '0;
        prod          = '0;
        case (req_i.op)
            OP_SUM_REGS, OP_SUM_CARRY: begin
                cin = (req_i.op == OP_SUM_CARRY) & req_i.sreg[`ABX_FLAG_C];
                ar  = f_add(req_i.rd_val, req_i.rr_val, cin);
            end
            OP_DIFFERENCE_REGS, OP_COMPARE_REGS: begin
                ar = f_sub(req_i.rd_val, req_i.rr_val, 1'b0);
            end
            OP_DIFFERENCE_CONSTANT: begin
                ar = f_sub(req_i.rd_val, req_i.imm, 1'b0);
            end
            OP_DIFFERENCE_WITH_BORROW: begin
                ar = f_sub(req_i.rd_val, req_i.rr_val, req_i.sreg[`ABX_FLAG_C]);
            end
            OP_CONSTANT_DIFFERENCE_BORROW: begin
                ar = f_sub(req_i.rd_val, req_i.imm, req_i.sreg[`ABX_FLAG_C]);
            end
            OP_ARITH_INVERSE: begin
                ar = f_sub(`ABX_BYTE_ZERO, req_i.rd_val, 1'b0);
            end
            default: begin
                ar = '0;
            end
        endcase

        // Byte results of the logic class.
        case (req_i.op)
            OP_CONJ_REGS:          lv = req_i.rd_val & req_i.rr_val;
            OP_BITWISE_CONJ_CONST: lv = req_i.rd_val & req_i.imm;
            OP_DISJ_REGS:          lv = req_i.rd_val | req_i.rr_val;
            OP_BITWISE_DISJ_CONST: lv = req_i.rd_val | req_i.imm;
            OP_BITWISE_XDISJ_REGS: lv = req_i.rd_val ^ req_i.rr_val;
            OP_BIT_INVERSION:      lv = `ABX_BYTE_ONES - req_i.rd_val;
            OP_SET_BITS_MASK:      lv = req_i.rd_val | req_i.imm;
            OP_CLEAR_BITS_MASK:    lv = req_i.rd_val & (`ABX_BYTE_ONES - req_i.imm);
            OP_ZERO_SIGN_TEST:     lv = req_i.rd_val & req_i.rd_val;
            OP_ZERO_REGISTER:      lv = req_i.rd_val ^ req_i.rd_val;
            default:               lv = `ABX_BYTE_ZERO;
        endcase

        case (req_i.op)
            OP_SUM_REGS, OP_SUM_CARRY, OP_DIFFERENCE_REGS, OP_DIFFERENCE_CONSTANT,
            OP_DIFFERENCE_WITH_BORROW, OP_CONSTANT_DIFFERENCE_BORROW,
            OP_ARITH_INVERSE, OP_COMPARE_REGS: begin
                res_d.lo_we   = (req_i.op != OP_COMPARE_REGS);
                res_d.wr_data = {8'h00, ar[7:0]};
                res_d.flag_we = `ABX_MSK_ARITH;
                res_d.flags[`ABX_FLAG_H] = ar[10];
                res_d.flags[`ABX_FLAG_V] = ar[9];
                res_d.flags[`ABX_FLAG_C] = ar[8];
                res_d.flags[`ABX_FLAG_N] = ar[7];
                res_d.flags[`ABX_FLAG_Z] = (ar[7:0] == `ABX_BYTE_ZERO);
                if (req_i.op == OP_DIFFERENCE_WITH_BORROW ||
                    req_i.op == OP_CONSTANT_DIFFERENCE_BORROW) begin
                    res_d.flags[`ABX_FLAG_Z] = (ar[7:0] == `ABX_BYTE_ZERO) &
                                               req_i.sreg[`ABX_FLAG_Z];
                end
                if (req_i.op == OP_ARITH_INVERSE) begin
                    res_d.flags[`ABX_FLAG_C] = (ar[7:0] != `ABX_BYTE_ZERO);
                    res_d.flags[`ABX_FLAG_V] = (ar[7:0] == `ABX_SIGN_MIN);
                    res_d.flags[`ABX_FLAG_H] = ar[3] | req_i.rd_val[3];
                end
            end
            OP_CONJ_REGS, OP_BITWISE_CONJ_CONST, OP_DISJ_REGS, OP_BITWISE_DISJ_CONST,
            OP_BITWISE_XDISJ_REGS, OP_BIT_INVERSION, OP_SET_BITS_MASK,
            OP_CLEAR_BITS_MASK, OP_ZERO_SIGN_TEST, OP_ZERO_REGISTER: begin
                res_d.lo_we   = 1'b1;
                res_d.wr_data = {8'h00, lv};
                res_d.flag_we = `ABX_MSK_LOGIC;
                res_d.flags[`ABX_FLAG_V] = 1'b0;
                res_d.flags[`ABX_FLAG_N] = lv[7];
                res_d.flags[`ABX_FLAG_Z] = (lv == `ABX_BYTE_ZERO);
                if (req_i.op == OP_BIT_INVERSION) begin
                    res_d.flag_we = `ABX_MSK_INV;
                    res_d.flags[`ABX_FLAG_C] = 1'b1;
                end
            end
            OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_DIFFERENCE: begin
                if (req_i.op == OP_WORD_IMMEDIATE_SUM) begin
                    wr = wv + {10'h000, req_i.imm[`ABX_WIMM_W-1:0]};
                    res_d.flags[`ABX_FLAG_V] = ~wv[15] & wr[15];
                    res_d.flags[`ABX_FLAG_C] = wv[15] & ~wr[15];
                end else begin
                    wr = wv - {10'h000, req_i.imm[`ABX_WIMM_W-1:0]};
                    res_d.flags[`ABX_FLAG_V] = wv[15] & ~wr[15];
                    res_d.flags[`ABX_FLAG_C] = ~wv[15] & wr[15];
                end
                res_d.lo_we   = 1'b1;
                res_d.hi_we   = 1'b1;
                res_d.wr_data = wr;
                res_d.flag_we = `ABX_MSK_WORD;
                res_d.flags[`ABX_FLAG_N] = wr[15];
                res_d.flags[`ABX_FLAG_Z] = (wr == 16'h0000);
                res_d.flags[`ABX_FLAG_S] = wr[15] ^ res_d.flags[`ABX_FLAG_V];
                cyc_d = `ABX_CYC_WORD;
            end
            OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
            OP_FRAC_UNSIGNED_PRODUCT, OP_FRAC_SIGNED_PRODUCT, OP_FRAC_MIXED_PRODUCT: begin
                // Sign extension chooses the product kind.
                ma = {req_i.rd_val[7] & (req_i.op != OP_UNSIGNED_PRODUCT) &
                      (req_i.op != OP_FRAC_UNSIGNED_PRODUCT), req_i.rd_val};
                mb = {req_i.rr_val[7] & ((req_i.op == OP_SIGNED_PRODUCT) |
                      (req_i.op == OP_FRAC_SIGNED_PRODUCT)), req_i.rr_val};
                mp   = 18'($signed(ma) * $signed(mb));
                prod = mp[15:0];
                res_d.flags[`ABX_FLAG_C] = prod[15];
                if (req_i.op == OP_FRAC_UNSIGNED_PRODUCT || req_i.op == OP_FRAC_SIGNED_PRODUCT
                    || req_i.op == OP_FRAC_MIXED_PRODUCT) begin
                    prod = {prod[14:0], 1'b0};
                end
                res_d.lo_we   = 1'b1;
                res_d.hi_we   = 1'b1;
                res_d.wr_idx  = `ABX_PROD_REG;
                res_d.wr_data = prod;
                res_d.flag_we = `ABX_MSK_MUL;
                res_d.flags[`ABX_FLAG_Z] = (prod == 16'h0000);
                cyc_d = `ABX_CYC_MUL;
            end
            OP_RELATIVE_JUMP, OP_RELATIVE_CALL: begin
                res_d.pc_load   = 1'b1;
                res_d.pc_next   = rel_addr;
                res_d.push      = (req_i.op == OP_RELATIVE_CALL);
                res_d.push_addr = req_i.pc + `ABX_PC_W'(1);
                cyc_d = res_d.push ? `ABX_CYC_RELATIVE_CALL : `ABX_CYC_RJUMP;
            end
            OP_INDIRECT_JUMP, OP_INDIRECT_CALL: begin
                res_d.pc_load   = 1'b1;
                res_d.pc_next   = `ABX_PC_W'(req_i.zptr);
                res_d.push      = (req_i.op == OP_INDIRECT_CALL);
                res_d.push_addr = req_i.pc + `ABX_PC_W'(1);
                cyc_d = res_d.push ? `ABX_CYC_RELATIVE_CALL : `ABX_CYC_RJUMP;
            end
            OP_EXTENDED_INDIRECT_JUMP: begin
                res_d.pc_load = 1'b1;
                res_d.pc_next = ext_addr[`ABX_PC_W-1:0];
                cyc_d = `ABX_CYC_RJUMP;
            end
            OP_EXTENDED_INDIRECT_CALL: begin
                res_d.pc_load   = 1'b1;
                res_d.pc_next   = ext_addr[`ABX_PC_W-1:0];
                res_d.push      = 1'b1;
                res_d.push_addr = req_i.pc + `ABX_PC_W'(1);
                cyc_d = `ABX_CYC_RELATIVE_CALL;
            end
            OP_DIRECT_JUMP, OP_DIRECT_CALL: begin
                // Absolute target; call returns past the address word.
                res_d.pc_load   = 1'b1;
                res_d.pc_next   = req_i.target;
                res_d.push      = (req_i.op == OP_DIRECT_CALL);
                res_d.push_addr = req_i.pc + `ABX_PC_W'(2);
                cyc_d = res_d.push ? `ABX_CYC_DCALL : `ABX_CYC_DJUMP;
            end
            OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: begin
                res_d.pc_load = 1'b1;
                res_d.pc_next = req_i.stack_addr;
                res_d.pop     = 1'b1;
                if (req_i.op == OP_INTERRUPT_EXIT) begin
                    res_d.flag_we = `ABX_MSK_INT;
                    res_d.flags[`ABX_FLAG_I] = 1'b1;
                end
                cyc_d = `ABX_CYC_EXIT;
            end
            OP_COMPARE_SKIP_EQUAL: begin
                // Skip on equality; unequal falls through normally.
                if (req_i.rd_val == req_i.rr_val) begin
                    res_d.pc_load = 1'b1;
                    res_d.pc_next = req_i.pc + (req_i.next_two_word ?
                                                `ABX_PC_W'(3) : `ABX_PC_W'(2));
                    cyc_d = req_i.next_two_word ? `ABX_CYC_SKIP2 : `ABX_CYC_SKIP1;
                end
            end
            default: begin
                cyc_d = `ABX_CYC_ALU;
            end
        endcase
    end

    // ======================================================================
    // Sequencer.

    // The cycle counter stretches each instruction to its required length;
    // the write-back is issued once, at the end, so fetch sees one event.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            cnt_q   <= 3'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (fetch) begin
                        state_q <= ST_EXEC;
                        cnt_q   <= cyc_d - 3'h1;
                    end
                end
                ST_EXEC: begin
                    if (cnt_q == 3'h0) begin
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    cnt_q   <= 3'h0;
                end
            endcase
        end
    end

    // Completion strobe, one cycle wide.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == ST_EXEC) && (cnt_q == 3'h0);
        end
    end

    // Held results; fields are meaningful only while done_o is high.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_q <= '0;
        end else if (fetch) begin
            res_q <= res_d;
        end
    end

    assign done_o = done_q;
    assign res_o  = res_q;

endmodule // abx_exec

// >>> abx_defs.svh
`ifndef ABX_DEFS_SVH
`define ABX_DEFS_SVH

// ==========================================================================
// Status flag bit positions.
`define ABX_FLAG_C    0
`define ABX_FLAG_Z    1
`define ABX_FLAG_N    2
`define ABX_FLAG_V    3
`define ABX_FLAG_S    4
`define ABX_FLAG_H    5
`define ABX_FLAG_I    7

// ==========================================================================
// Flag update masks, one bit per status flag.
`define ABX_MSK_ARITH 8'h2f
`define ABX_MSK_LOGIC 8'h0e
`define ABX_MSK_INV   8'h0f
`define ABX_MSK_WORD  8'h1f
`define ABX_MSK_MUL   8'h03
`define ABX_MSK_INT   8'h80
`define ABX_MSK_NONE  8'h00

// ==========================================================================
// Widths and constants.
`define ABX_PC_W      22
`define ABX_WIMM_W    6
`define ABX_PROD_REG  5'h00
`define ABX_BYTE_ONES 8'hff
`define ABX_BYTE_ZERO 8'h00
`define ABX_SIGN_MIN  8'h80

// ==========================================================================
// Clock counts per instruction class.
`define ABX_CYC_ALU   3'h1
`define ABX_CYC_WORD  3'h2
`define ABX_CYC_MUL   3'h2
`define ABX_CYC_RJUMP 3'h2
`define ABX_CYC_RELATIVE_CALL 3'h4
`define ABX_CYC_DJUMP 3'h3
`define ABX_CYC_DCALL 3'h5
`define ABX_CYC_EXIT  3'h5
`define ABX_CYC_SKIP1 3'h2
`define ABX_CYC_SKIP2 3'h3

`endif

// >>> abx_pkg.sv
`include "abx_defs.svh"

package abx_pkg;

    // Operations that the execution unit carries out.
    typedef enum logic [5:0] {
        OP_SUM_REGS, OP_SUM_CARRY, OP_WORD_IMMEDIATE_SUM, OP_DIFFERENCE_REGS,
        OP_DIFFERENCE_CONSTANT, OP_DIFFERENCE_WITH_BORROW, OP_CONSTANT_DIFFERENCE_BORROW,
        OP_WORD_IMMEDIATE_DIFFERENCE, OP_CONJ_REGS, OP_BITWISE_CONJ_CONST, OP_DISJ_REGS,
        OP_BITWISE_DISJ_CONST, OP_BITWISE_XDISJ_REGS, OP_BIT_INVERSION, OP_ARITH_INVERSE,
        OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK, OP_ZERO_SIGN_TEST, OP_ZERO_REGISTER,
        OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
        OP_FRAC_UNSIGNED_PRODUCT, OP_FRAC_SIGNED_PRODUCT, OP_FRAC_MIXED_PRODUCT,
        OP_RELATIVE_JUMP, OP_RELATIVE_CALL, OP_INDIRECT_JUMP, OP_INDIRECT_CALL,
        OP_EXTENDED_INDIRECT_JUMP, OP_EXTENDED_INDIRECT_CALL, OP_DIRECT_JUMP,
        OP_DIRECT_CALL, OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT, OP_COMPARE_SKIP_EQUAL,
        OP_COMPARE_REGS
    } abx_op_t;

    // Decoded instruction with its operand values.
    typedef struct packed {
        abx_op_t                 op;
        logic [4:0]              rd_idx;
        logic [7:0]              rd_val;
        logic [7:0]              rd_hi_val;
        logic [7:0]              rr_val;
        logic [7:0]              imm;
        logic [11:0]             offset;
        logic [`ABX_PC_W-1:0]    target;
        logic [`ABX_PC_W-1:0]    pc;
        logic [15:0]             zptr;
        logic [7:0]              ext_high;
        logic [`ABX_PC_W-1:0]    stack_addr;
        logic [7:0]              sreg;
        logic                    next_two_word;
    } abx_req_t;

    // Write-back towards register file, status register, fetch and stack.
    typedef struct packed {
        logic                    lo_we;
        logic                    hi_we;
        logic [4:0]              wr_idx;
        logic [15:0]             wr_data;
        logic [7:0]              flags;
        logic [7:0]              flag_we;
        logic                    pc_load;
        logic [`ABX_PC_W-1:0]    pc_next;
        logic                    push;
        logic [`ABX_PC_W-1:0]    push_addr;
        logic                    pop;
    } abx_res_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } abx_state_t;

endpackage

// >>> abx_exec_monitor.sv
`timescale 1ns/1ps
`include "abx_defs.svh"

module abx_exec_monitor
    import abx_pkg::*;
(
    input wire logic     clk_i,
    input wire logic     rst_i,
    input wire logic     start_i,
    input wire abx_req_t req_i,
    input wire logic     ready_o,
    input wire logic     done_o,
    input wire abx_res_t res_o
);
    // ====================
    // Request acceptance, shared by every check below except chk_done_ready and chk_done_pulse.
    logic go;
    assign go = start_i && ready_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ====================
    // Handshake: a one-cycle done that frees the unit, results held between requests.
    chk_done_ready:
        assert property (done_o |-> ready_o) else $error("done while busy");
    chk_done_pulse:
        assert property (done_o |=> !done_o) else $error("done longer than a cycle");
    chk_res_hold:
        assert property (!go |=> $stable(res_o)) else $error("result moved while idle");

    // ====================
    // Cycle counts and results of selected operations.
    chk_sum_timing:
        assert property (go && req_i.op == OP_SUM_REGS |=> !done_o ##1 done_o)
        else $error("sum not done after one clock");
    chk_jump_timing:
        assert property (go && req_i.op == OP_DIRECT_JUMP |=> !ready_o [*3] ##1 done_o)
        else $error("direct jump not three clocks");
    chk_call_timing:
        assert property (go && req_i.op == OP_DIRECT_CALL |=> !ready_o [*5] ##1 done_o)
        else $error("direct call not five clocks");
    chk_product_pair:
        assert property (go && req_i.op == OP_UNSIGNED_PRODUCT |=> res_o.wr_idx == 5'h00
            && res_o.hi_we && res_o.flag_we == 8'h03) else $error("product target wrong");
    chk_xor_value:
        assert property (go && req_i.op == OP_BITWISE_XDISJ_REGS |=> res_o.wr_data[7:0] ==
            ($past(req_i.rd_val) ^ $past(req_i.rr_val))) else $error("xor result wrong");
    chk_exit_pop:
        assert property (go && req_i.op == OP_SUBROUTINE_EXIT |=> res_o.pop
            && res_o.pc_next == $past(req_i.stack_addr)) else $error("return target wrong");
    chk_compare_quiet:
        assert property (go && req_i.op == OP_COMPARE_REGS |=> !res_o.lo_we
            && res_o.flag_we == 8'h2f) else $error("compare wrote a register");
endmodule // abx_exec_monitor

// >>> abx_far_model.sv
`timescale 1ns/1ps
`include "abx_defs.svh"

module abx_far_model
    import abx_pkg::*;
(
    input wire logic     clk_i,
    input wire logic     done_i,
    input wire abx_res_t res_i
);
    // ====================
    // Register file and fetch counter that sit beyond the unit.
    logic [7:0]           rf [32];
    logic [`ABX_PC_W-1:0] pc_q;

    // Results count only in the done cycle, since they stand stale for long spans.
    always_ff @(posedge clk_i) begin
        if (done_i && res_i.lo_we) begin
            rf[res_i.wr_idx] <= res_i.wr_data[7:0];
        end
        if (done_i && res_i.hi_we) begin
            rf[res_i.wr_idx + 5'h01] <= res_i.wr_data[15:8];
        end
        if (done_i && res_i.pc_load) begin
            pc_q <= res_i.pc_next;
        end
    end
endmodule // abx_far_model

// >>> testbench.sv
`timescale 1ns/1ps
`include "abx_defs.svh"

module testbench
    import abx_pkg::*;
;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic         start_i = 1'b0;
    abx_req_t     req_i = '0;
    abx_req_t     r;
    logic         ready_o;
    logic         done_o;
    abx_res_t     res_o;
    logic [159:0] bits;
    logic [31:0]  seed = 32'hc716;
    int           mismatches = 0;
    int           comparisons = 0;
    int           cycles = 0;

    // Free-running clock; reset is released from the main sequence.
    always #5 clk_i = ~clk_i;

    abx_exec u_abx_exec (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .req_i(req_i),
                         .ready_o(ready_o), .done_o(done_o), .res_o(res_o));
    abx_far_model u_abx_far_model (.clk_i(clk_i), .done_i(done_o), .res_i(res_o));

    // Xorshift source so every run sees the same operands.
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Reference model with integers, then one request and its checks.
    task automatic run(input abx_req_t q);
        int a, b, c, k, o, d, m, n, p, cf, z, wd, wi, we, t;
        a = q.rd_val;
        b = q.rr_val;
        c = q.sreg[0];
        k = q.imm;
        o = $signed(q.offset);
        p = -1;
        wi = q.rd_idx;
        case (q.op)
            OP_SUM_REGS:                          d = a + b;
            OP_SUM_CARRY:                         d = a + b + c;
            OP_DIFFERENCE_REGS, OP_COMPARE_REGS:  d = a - b;
            OP_DIFFERENCE_CONSTANT:               d = a - k;
            OP_DIFFERENCE_WITH_BORROW:            d = a - b - c;
            OP_CONSTANT_DIFFERENCE_BORROW:        d = a - k - c;
            OP_CONJ_REGS:                         d = a & b;
            OP_BITWISE_CONJ_CONST:                d = a & k;
            OP_DISJ_REGS:                         d = a | b;
            OP_BITWISE_DISJ_CONST, OP_SET_BITS_MASK: d = a | k;
            OP_BITWISE_XDISJ_REGS:                d = a ^ b;
            OP_BIT_INVERSION:                     d = 255 - a;
            OP_ARITH_INVERSE:                     d = 0 - a;
            OP_CLEAR_BITS_MASK:                   d = a & (255 - k);
            OP_ZERO_SIGN_TEST:                    d = a & a;
            OP_ZERO_REGISTER:                     d = a ^ a;
            OP_WORD_IMMEDIATE_SUM:                d = q.rd_hi_val * 256 + a + k % 64;
            OP_WORD_IMMEDIATE_DIFFERENCE:         d = q.rd_hi_val * 256 + a - k % 64;
            OP_UNSIGNED_PRODUCT, OP_FRAC_UNSIGNED_PRODUCT: d = a * b;
            OP_SIGNED_PRODUCT, OP_FRAC_SIGNED_PRODUCT: d = $signed(q.rd_val) * $signed(q.rr_val);
            OP_MIXED_SIGN_PRODUCT, OP_FRAC_MIXED_PRODUCT: d = $signed(q.rd_val) * b;
            OP_RELATIVE_JUMP, OP_RELATIVE_CALL:   p = (q.pc + o + 1) & 32'h3fffff;
            OP_INDIRECT_JUMP, OP_INDIRECT_CALL:   p = q.zptr;
            OP_EXTENDED_INDIRECT_JUMP, OP_EXTENDED_INDIRECT_CALL: p = {q.ext_high, q.zptr};
            OP_DIRECT_JUMP, OP_DIRECT_CALL:       p = q.target;
            OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: p = q.stack_addr;
            OP_COMPARE_SKIP_EQUAL:                p = a == b ? q.pc + 2 + q.next_two_word : -1;
            default:                              d = 0;
        endcase
        case (q.op) inside
            [OP_CONJ_REGS:OP_BITWISE_XDISJ_REGS], [OP_SET_BITS_MASK:OP_ZERO_REGISTER]: m = 8'h0e;
            OP_BIT_INVERSION:                                     m = 8'h0f;
            OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_DIFFERENCE:  m = 8'h1f;
            [OP_UNSIGNED_PRODUCT:OP_FRAC_MIXED_PRODUCT]:          m = 8'h03;
            [OP_RELATIVE_JUMP:OP_SUBROUTINE_EXIT], OP_COMPARE_SKIP_EQUAL: m = 8'h00;
            OP_INTERRUPT_EXIT:                                    m = 8'h80;
            default:                                              m = 8'h2f;
        endcase
        wd = m == 8'h1f || m == 8'h03;
        cf = wd ? d < 0 || d > 65535 : d < 0 || d > 255;
        if (m == 8'h03) cf = d[15];
        if (m == 8'h03) wi = 0;
        if (m == 8'h0f) cf = 1;
        if (q.op inside {[OP_FRAC_UNSIGNED_PRODUCT:OP_FRAC_MIXED_PRODUCT]}) d = d * 2;
        d = d & (wd ? 65535 : 255);
        z = d == 0;
        if (q.op inside {OP_DIFFERENCE_WITH_BORROW, OP_CONSTANT_DIFFERENCE_BORROW}) z &= q.sreg[1];
        we = m != 8'h00 && m != 8'h80 && q.op != OP_COMPARE_REGS;
        case (q.op) inside
            OP_RELATIVE_CALL, OP_INDIRECT_CALL, OP_EXTENDED_INDIRECT_CALL: n = 4;
            OP_RELATIVE_JUMP, OP_INDIRECT_JUMP, OP_EXTENDED_INDIRECT_JUMP: n = 2;
            OP_DIRECT_JUMP:                      n = 3;
            [OP_DIRECT_CALL:OP_INTERRUPT_EXIT]:  n = 5;
            OP_COMPARE_SKIP_EQUAL:               n = p < 0 ? 1 : 2 + q.next_two_word;
            default:                             n = wd ? 2 : 1;
        endcase
        @(posedge clk_i);
        start_i <= 1'b1;
        req_i <= q;
        @(posedge clk_i);
        start_i <= 1'b0;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (done_o !== 1'b1 && t < 20);
        #1;
        cmp("cycles", n + 1, t);
        cmp("push", n == 4 || q.op == OP_DIRECT_CALL, res_o.push);
        cmp("flag_we", m, res_o.flag_we);
        if (m[1]) cmp("zero", z, res_o.flags[1]);
        if (m[0]) cmp("carry", cf, res_o.flags[0]);
        cmp("pc_load", p >= 0, res_o.pc_load);
        if (p >= 0) cmp("pc", p & 32'h3fffff, u_abx_far_model.pc_q);
        cmp("low_write", we, res_o.lo_we);
        if (we) cmp("low", d & 255, u_abx_far_model.rf[wi]);
        if (wd) cmp("high", d >> 8, u_abx_far_model.rf[wi + 1]);
        if (m == 8'h80) cmp("irq_enable", 1, res_o.flags[7]);
    endtask

    // Hang guard: a stuck handshake ends the run as a failure.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    // Every operation many times with random operands; equal operands half the time.
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 37 * 24; i++) begin
            bits = {xs(), xs(), xs(), xs(), xs()};
            r = bits[$bits(abx_req_t)-1:0];
            r.op = abx_op_t'(i % 37);
            r.rd_idx[0] = 1'b0;
            if (xs() % 2 == 1) r.rr_val = r.rd_val;
            run(r);
        end
        summarize();
    end
endmodule // testbench

bind abx_exec abx_exec_monitor u_abx_exec_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .start_i(start_i), .req_i(req_i), .ready_o(ready_o), .done_o(done_o), .res_o(res_o));
